// ### inc/emp_pkg.sv
// package for the external memory pin interface: widths, encodings, carriers
package emp_pkg;
    // ****************************************
    // widths
    // ****************************************
    localparam int ADDR_W  = 24;
    localparam int DATA_W  = 32;
    localparam int LANES   = 4;
    localparam int SD_BANKS = 2;

    // ****************************************
    // address bit positions
    // ****************************************
    localparam int BA_LO_BIT = 13;
    localparam int BA_HI_BIT = 14;
    localparam int AP_BIT    = 10;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic       STROBE_IDLE = 1'h1;
    localparam logic [3:0] LANE_IDLE   = 4'hf;
    localparam logic [1:0] CS_IDLE     = 2'h3;
    localparam logic [23:0] ADDR_RESET = 24'h000000;
    localparam logic [31:0] DATA_RESET = 32'h00000000;
    localparam logic        CKE_RESET  = 1'h0;

    // bus width encoding
    typedef enum logic [1:0] {
        EMP_W8  = 2'h1,
        EMP_W16 = 2'h2,
        EMP_W32 = 2'h3
    } emp_width_type;

    // sdram internal bank count
    typedef enum logic {
        EMP_BANKS2 = 1'h0,
        EMP_BANKS4 = 1'h1
    } emp_sdbanks_type;

    // sdram command presented by the core
    typedef enum logic [2:0] {
        EMP_SD_NOP   = 3'h0,
        EMP_SD_ACT   = 3'h1,
        EMP_SD_READ  = 3'h2,
        EMP_SD_WRITE = 3'h3,
        EMP_SD_PRE   = 3'h4,
        EMP_SD_REF   = 3'h5,
        EMP_SD_MRS   = 3'h6
    } emp_sdcmd_type;

    // one-cycle access request from the core
    typedef struct packed {
        logic            valid;
        logic            is_sdram;
        logic            sd_bank;
        emp_sdcmd_type   sd_cmd;
        emp_sdbanks_type sd_banks;
        logic [1:0]      sd_ibank;
        logic            auto_pre;
        logic            write;
        emp_width_type   width;
        logic [3:0]      lanes;
        logic [23:0]     addr;
        logic [31:0]     wdata;
    } emp_req_type;

    // pin state
    typedef struct packed {
        logic [23:0] addr;
        logic [31:0] dout;
        logic        dout_en;
        logic [1:0]  sd_cs_n;
        logic        ras_n;
        logic        cas_n;
        logic        we_n;
        logic        oe_n;
        logic [3:0]  be_n;
        logic        cke;
        logic [31:0] rdata;
        logic        rvalid;
        logic        rd_pending;
        logic        bad_width;
    } emp_state_type;
endpackage

// ### rtl/emp_pins.sv
// pin driver for the external memory interface (static banks and sdram)
`timescale 1ns/1ps
module emp_pins (
    input  wire logic                clock_i,
    input  wire logic                rstn_i,
    input  wire emp_pkg::emp_req_type req_i,
    input  wire logic                cke_req_i,
    input  wire logic [31:0]         external_data_bus_i,
    output logic [23:0]              addr_o,
    output logic [31:0]              external_data_bus_o,
    output logic                     external_data_bus_oe_o,
    output logic [1:0]               sdram_bank_select_n_o,
    output logic                     sdram_row_strobe_n_o,
    output logic                     sdram_column_strobe_n_o,
    output logic                     sdram_clock_enable_o,
    output logic                     shared_write_strobe_n_o,
    output logic                     read_output_enable_n_o,
    output logic [3:0]               byte_write_strobe_n_o,
    output logic [31:0]              rdata_o,
    output logic                     rvalid_o,
    output logic                     bad_width_o
);
    emp_pkg::emp_state_type state;
    emp_pkg::emp_state_type next_state;

    logic                   req_sd;
    logic                   req_st;
    logic                   sd_width_ok;
    logic                   sd_go;
    logic                   req_ok;
    logic                   sd_read;
    logic                   sd_write;
    logic                   sd_bank4;
    logic                   st_write;
    logic                   st_read;
    logic [1:0]             sd_cs_sel_n;
    logic [3:0]             lane_strobe_n;

    // ****************************************
    // request decode
    // ****************************************
    assign req_sd      = req_i.valid && req_i.is_sdram;
    assign req_st      = req_i.valid && !req_i.is_sdram;
    // 8-bit and the reserved code alike are refused for sdram
    assign sd_width_ok = (req_i.width == emp_pkg::EMP_W16) || (req_i.width == emp_pkg::EMP_W32);
    assign sd_go       = req_sd && sd_width_ok;
    assign req_ok      = req_st || sd_go;
    // commands other than read and write pass address bit 10 through
    assign sd_read     = (req_i.sd_cmd == emp_pkg::EMP_SD_READ);
    assign sd_write    = (req_i.sd_cmd == emp_pkg::EMP_SD_WRITE);
    assign sd_bank4    = (req_i.sd_banks == emp_pkg::EMP_BANKS4);
    assign st_write    = req_st && req_i.write;
    assign st_read     = req_st && !req_i.write;

    // ****************************************
    // per-bank chip selects and per-lane strobes
    // ****************************************
    // one select per sdram bank; row and column strobes stay shared
    for (genvar bank = 0; bank < emp_pkg::SD_BANKS; bank++) begin
        assign sd_cs_sel_n[bank] = (req_i.sd_bank != 1'(bank));
    end

    // enables arrive active high; static parts see write strobes, sdram sees masks
    for (genvar lane = 0; lane < emp_pkg::LANES; lane++) begin
        assign lane_strobe_n[lane] = ~req_i.lanes[lane];
    end

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        next_state = state;
        // strobes fall back to idle each cycle unless an access drives them
        next_state.sd_cs_n    = emp_pkg::CS_IDLE;
        next_state.ras_n      = emp_pkg::STROBE_IDLE;
        next_state.cas_n      = emp_pkg::STROBE_IDLE;
        next_state.we_n       = emp_pkg::STROBE_IDLE;
        next_state.oe_n       = emp_pkg::STROBE_IDLE;
        next_state.be_n       = emp_pkg::LANE_IDLE;
        next_state.dout_en    = 1'h0;
        next_state.rvalid     = 1'h0;
        next_state.rd_pending = 1'h0;
        next_state.cke        = cke_req_i;

        // no cas latency is modelled: data is taken one cycle after the strobe
        if (state.rd_pending) begin
            next_state.rdata  = external_data_bus_i;
            next_state.rvalid = 1'h1;
        end

        // a refused access leaves every pin idle and only raises the flag
        if (req_i.valid) begin
            next_state.bad_width = !req_ok;
        end

        // the address holds between accesses so the pins do not toggle needlessly
        if (req_ok) begin
            next_state.addr = req_i.addr;
        end

        // command spacing (activate to read and the like) is the requester's job
        if (sd_go) begin
            next_state.addr[emp_pkg::BA_LO_BIT] = req_i.sd_ibank[0];
            // two-bank parts leave bit 14 for the row/column map
            if (sd_bank4) begin
                next_state.addr[emp_pkg::BA_HI_BIT] = req_i.sd_ibank[1];
            end
            if (sd_read || sd_write) begin
                next_state.addr[emp_pkg::AP_BIT] = req_i.auto_pre;
            end
            next_state.sd_cs_n = sd_cs_sel_n;
            case (req_i.sd_cmd)
                emp_pkg::EMP_SD_ACT: begin
                    next_state.ras_n = 1'h0;
                end
                emp_pkg::EMP_SD_READ: begin
                    next_state.cas_n      = 1'h0;
                    next_state.oe_n       = 1'h0;
                    next_state.be_n       = lane_strobe_n;
                    next_state.rd_pending = 1'h1;
                end
                emp_pkg::EMP_SD_WRITE: begin
                    next_state.cas_n   = 1'h0;
                    next_state.we_n    = 1'h0;
                    next_state.be_n    = lane_strobe_n;
                    next_state.dout    = req_i.wdata;
                    next_state.dout_en = 1'h1;
                end
                emp_pkg::EMP_SD_PRE: begin
                    // bit 10 goes out as given: high closes every bank
                    next_state.ras_n = 1'h0;
                    next_state.we_n  = 1'h0;
                end
                emp_pkg::EMP_SD_REF: begin
                    next_state.ras_n = 1'h0;
                    next_state.cas_n = 1'h0;
                end
                emp_pkg::EMP_SD_MRS: begin
                    next_state.ras_n = 1'h0;
                    next_state.cas_n = 1'h0;
                    next_state.we_n  = 1'h0;
                end
                default: begin
                    // nop and unused codes select no bank
                    next_state.sd_cs_n = emp_pkg::CS_IDLE;
                end
            endcase
        end

        // static write: data and lane strobes stand for one cycle
        if (st_write) begin
            next_state.dout    = req_i.wdata;
            next_state.dout_en = 1'h1;
            next_state.be_n    = lane_strobe_n;
            // 8-bit and 32-bit static parts see only the byte strobes; only 16-bit drives the shared write strobe
            next_state.we_n    = (req_i.width == emp_pkg::EMP_W16) ? 1'h0 : 1'h1;
        end

        // static read: the bus is sampled at the edge that ends the strobe
        if (st_read) begin
            next_state.oe_n       = 1'h0;
            next_state.rd_pending = 1'h1;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    // sync reset parks every strobe high and drops any read in flight
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            state.addr       <= emp_pkg::ADDR_RESET;
            state.dout       <= emp_pkg::DATA_RESET;
            state.dout_en    <= 1'h0;
            state.sd_cs_n    <= emp_pkg::CS_IDLE;
            state.ras_n      <= emp_pkg::STROBE_IDLE;
            state.cas_n      <= emp_pkg::STROBE_IDLE;
            state.we_n       <= emp_pkg::STROBE_IDLE;
            state.oe_n       <= emp_pkg::STROBE_IDLE;
            state.be_n       <= emp_pkg::LANE_IDLE;
            state.cke        <= emp_pkg::CKE_RESET;
            state.rdata      <= emp_pkg::DATA_RESET;
            state.rvalid     <= 1'h0;
            state.rd_pending <= 1'h0;
            state.bad_width  <= 1'h0;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // pins
    // ****************************************
    assign addr_o                  = state.addr;
    assign external_data_bus_o     = state.dout;
    assign external_data_bus_oe_o  = state.dout_en;
    assign sdram_bank_select_n_o   = state.sd_cs_n;
    assign sdram_row_strobe_n_o    = state.ras_n;
    assign sdram_column_strobe_n_o = state.cas_n;
    assign sdram_clock_enable_o    = state.cke;
    assign shared_write_strobe_n_o = state.we_n;
    assign read_output_enable_n_o  = state.oe_n;
    assign byte_write_strobe_n_o   = state.be_n;
    assign rdata_o                 = state.rdata;
    assign rvalid_o                = state.rvalid;
    assign bad_width_o             = state.bad_width;
endmodule

// ### test/emp_mem_model.sv
// memory device model on the far side of the pins
`timescale 1ns/1ps
module emp_mem_model (
    input  wire logic        clock_i,
    input  wire logic        oe_n_i,
    input  wire logic        doe_i,
    input  wire logic [31:0] dout_i,
    output logic      [31:0] din_o
);
    logic [31:0] word = 32'h0;
    logic [31:0] last = 32'h0;
    // released bus toggles so a stale sample never looks right
    assign din_o = !oe_n_i ? word : ~last;
    always @(posedge clock_i) begin
        last <= din_o;
        if (doe_i) begin
            word <= dout_i;
        end
    end
endmodule

// ### test/emp_pins_asserts.sv
// assertion checker for the external memory pin driver
`timescale 1ns/1ps
module emp_pins_asserts (
    input wire logic                 clock_i,
    input wire logic                 rstn_i,
    input wire emp_pkg::emp_req_type req_i,
    input wire logic                 cke_req_i,
    input wire logic [23:0]          addr_o,
    input wire logic [31:0]          external_data_bus_o,
    input wire logic                 external_data_bus_oe_o,
    input wire logic [1:0]           sdram_bank_select_n_o,
    input wire logic                 sdram_row_strobe_n_o,
    input wire logic                 sdram_column_strobe_n_o,
    input wire logic                 sdram_clock_enable_o,
    input wire logic                 shared_write_strobe_n_o,
    input wire logic                 read_output_enable_n_o,
    input wire logic [3:0]           byte_write_strobe_n_o,
    input wire logic                 rvalid_o,
    input wire logic                 bad_width_o
);
    wire logic sd = req_i.valid && req_i.is_sdram && req_i.width inside {emp_pkg::EMP_W16, emp_pkg::EMP_W32};
    wire logic st = req_i.valid && !req_i.is_sdram;
    wire logic idle = &{sdram_bank_select_n_o, sdram_row_strobe_n_o, sdram_column_strobe_n_o,
        shared_write_strobe_n_o, read_output_enable_n_o, byte_write_strobe_n_o} && !external_data_bus_oe_o;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    AST_RESET_IDLE: assert property ($rose(rstn_i) |-> idle && !rvalid_o) else $error("pins busy after reset");
    AST_IDLE: assert property (!req_i.valid |=> idle) else $error("strobe without request");
    AST_CS: assert property (sd && req_i.sd_cmd != emp_pkg::EMP_SD_NOP |=>
        sdram_bank_select_n_o == ~(2'h1 << $past(req_i.sd_bank))) else $error("wrong chip select");
    AST_BANK: assert property (sd |=> addr_o[13] == $past(req_i.sd_ibank[0]) &&
        ($past(req_i.sd_banks) == emp_pkg::EMP_BANKS2 || addr_o[14] == $past(req_i.sd_ibank[1])))
        else $error("bank select bits wrong");
    AST_AP: assert property (sd && req_i.auto_pre && req_i.sd_cmd inside {emp_pkg::EMP_SD_READ,
        emp_pkg::EMP_SD_WRITE} |=> addr_o[10]) else $error("auto precharge bit low");
    AST_W8: assert property (req_i.valid && req_i.is_sdram && !sd
        |=> bad_width_o && &sdram_bank_select_n_o) else $error("8-bit sdram not refused");
    AST_ROW: assert property (sd && req_i.sd_cmd == emp_pkg::EMP_SD_ACT |=>
        !sdram_row_strobe_n_o && sdram_column_strobe_n_o) else $error("activate strobes wrong");
    AST_COL: assert property (sd && req_i.sd_cmd == emp_pkg::EMP_SD_READ |=>
        !sdram_column_strobe_n_o && sdram_row_strobe_n_o && !read_output_enable_n_o) else $error("read strobes wrong");
    AST_WE: assert property (st && req_i.write |=>
        shared_write_strobe_n_o == ($past(req_i.width) != emp_pkg::EMP_W16)) else $error("write strobe wrong");
    AST_LANES: assert property (st && req_i.write |=> byte_write_strobe_n_o == ~$past(req_i.lanes) &&
        external_data_bus_oe_o && external_data_bus_o == $past(req_i.wdata)) else $error("write lanes wrong");
    AST_OE: assert property (st && !req_i.write |=> !read_output_enable_n_o ##1 rvalid_o) else $error("read late");
    AST_CKE: assert property ($past(rstn_i) |-> sdram_clock_enable_o == $past(cke_req_i)) else $error("cke lag");
    AST_ADDR: assert property (st |=> addr_o == $past(req_i.addr)) else $error("address not driven");
    COV_SDREAD: cover property (sd && req_i.sd_cmd == emp_pkg::EMP_SD_READ ##2 rvalid_o);
    COV_W8: cover property (req_i.valid && req_i.is_sdram && req_i.width == emp_pkg::EMP_W8);
    COV_WE16: cover property (st && req_i.write ##1 !shared_write_strobe_n_o);
endmodule
bind emp_pins emp_pins_asserts u_chk (.*);

// ### test/emp_pins_tb.sv
// self-checking testbench for the external memory pin driver
`timescale 1ns/1ps
module emp_pins_tb;
    logic clock_i = 1'b0, rstn_i = 1'b0, cke_req_i = 1'b0;
    emp_pkg::emp_req_type req_i = '0, r;
    logic [31:0] din, dout, rdata, wd;
    logic [23:0] addr;
    logic [3:0]  be_n;
    logic [1:0]  cs_n;
    logic        doe, ras_n, cas_n, cke, we_n, oe_n, rvalid, bad;
    logic [2:0]  tbl [7] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
    int          num_errors = 0, compares = 0, cycles = 0;
    emp_pins uut (.clock_i(clock_i), .rstn_i(rstn_i), .req_i(req_i), .cke_req_i(cke_req_i),
        .external_data_bus_i(din), .addr_o(addr), .external_data_bus_o(dout), .external_data_bus_oe_o(doe),
        .sdram_bank_select_n_o(cs_n), .sdram_row_strobe_n_o(ras_n), .sdram_column_strobe_n_o(cas_n),
        .sdram_clock_enable_o(cke), .shared_write_strobe_n_o(we_n), .read_output_enable_n_o(oe_n),
        .byte_write_strobe_n_o(be_n), .rdata_o(rdata), .rvalid_o(rvalid), .bad_width_o(bad));
    emp_mem_model u_mem (.clock_i(clock_i), .oe_n_i(oe_n), .doe_i(doe), .dout_i(dout), .din_o(din));
    always #25 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            results();
        end
    end
    task check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // pins answer at the edge between the two falling edges
    task send(input emp_pkg::emp_req_type q);
        @(negedge clock_i);
        req_i = q;
        @(negedge clock_i);
        req_i.valid = 1'b0;
    endtask
    task t_static;
        for (int w = 1; w < 4; w++) begin
            r = '0; r.valid = 1; r.write = 1; r.width = emp_pkg::emp_width_type'(w);
            r.lanes = 4'h5; r.addr = 24'hffffff; r.wdata = 32'ha5c3_0f00 + w;
            send(r);
            check(we_n, w != 2);
            check({doe, dout, be_n}, {1'b1, r.wdata, 4'ha});
            check(addr, 24'hffffff);
        end
        r.write = 0; r.addr = 24'h000001;
        send(r);
        check({oe_n, we_n, addr}, {2'h1, 24'h000001});
        @(negedge clock_i);
        check({rvalid, rdata}, {1'b1, 32'ha5c3_0f03});
    endtask
    task t_sdram;
        for (int i = 0; i < 7; i++) begin
            r = '0; r.valid = 1; r.is_sdram = 1; r.width = emp_pkg::EMP_W16; r.auto_pre = 1;
            r.sd_cmd = emp_pkg::emp_sdcmd_type'(i); r.sd_bank = i[0]; r.sd_ibank = i[1:0];
            r.sd_banks = emp_pkg::EMP_BANKS4;
            send(r);
            check({cs_n, ras_n, cas_n, we_n}, {(i == 0) ? 2'h3 : ~(2'h1 << i[0]), tbl[i]});
            if (i > 0) check({addr[14:13], addr[10]}, {i[1:0], i == 2 || i == 3});
        end
        r.sd_banks = emp_pkg::EMP_BANKS2; r.sd_ibank = 2'h1; r.addr = 24'h004000;
        send(r);
        check(addr[14:13], 2'h3);
        r.width = emp_pkg::EMP_W8; r.sd_cmd = emp_pkg::EMP_SD_READ;
        send(r);
        check({bad, cs_n, cas_n, oe_n}, {5'h1f});
        r.width = emp_pkg::emp_width_type'(2'h0);
        send(r);
        check({bad, cs_n, cas_n, oe_n}, {5'h1f});
        r.width = emp_pkg::EMP_W32;
        send(r);
        check({bad, cas_n}, 2'h0);
    endtask
    task t_cke;
        cke_req_i = 1'b1;
        @(negedge clock_i);
        check(cke, 1'b1);
        cke_req_i = 1'b0;
        @(negedge clock_i);
        check(cke, 1'b0);
    endtask
    initial begin
        repeat (3) @(negedge clock_i);
        check({cs_n, ras_n, cas_n, we_n, oe_n, be_n, doe, cke, rvalid}, {13'h1ff8});
        rstn_i = 1'b1;
        @(negedge clock_i);
        check({cs_n, ras_n, cas_n, we_n, oe_n, be_n, doe, addr}, {10'h3ff, 25'h0});
        t_static();
        t_sdram();
        t_cke();
        results();
    end
endmodule
